// [pkg/adcsc_pkg.sv]
// package for the serial channel control block: field layout, counts, timing
// assumes the serial pins are sampled on the 10 MHz system clock
package adcsc_pkg;
    // ===========================================================
    // control byte layout
    localparam int           CTRL_BITS      = 8;
    localparam int           CHAN_MSB       = 5;
    localparam int           CHAN_LSB       = 3;
    localparam logic [2:0]   CHAN_RESET     = 3'h0;
    localparam logic [7:0]   CTRL_RESET     = 8'h00;
    // ===========================================================
    // conversion sequencing
    localparam int           RESULT_BITS    = 12;
    localparam int           EDGES_PER_CONV = 16;
    localparam int           LEAD_ZEROS     = 4;
    localparam int           TRACK_CYCLES   = 3;
    localparam logic [4:0]   CNT_LAST       = 5'h10;
    localparam logic [4:0]   CNT_HOLD       = 5'h04;
    localparam logic [4:0]   CNT_CTRL_END   = 5'h08;
    localparam logic [11:0]  RESULT_RESET   = 12'h000;
    // ===========================================================
    // phase of one conversion
    typedef enum logic [1:0] {ADCSC_OFF, ADCSC_TRACK, ADCSC_HOLD, ADCSC_SLEEP} adcsc_phase_t;
endpackage

// [hdl/adcsc_edge.sv]
// edge detector for the sampled serial clock and frame select
// assumes inputs are synchronous to clk
`timescale 1ns/1ns
module adcsc_edge
    import adcsc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic sig,
    output logic      rise,
    output logic      fall
);
    logic prev;
    logic next_prev;

    // =======================================================
    // previous sample
    always_comb begin
        next_prev = sig;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev <= 1'b1; // reset high for both lines; only frame select idles high
        end else begin
            prev <= next_prev;
        end
    end

    assign rise = sig & ~prev;
    assign fall = ~sig & prev;
endmodule

// [hdl/adcsc_top.sv]
// serial control and readout of an eight-channel 12-bit converter
// assumes host drives frame_sel_n, sclk, sdi synchronous to clk, result arrives
// from the converter core by the start of each conversion's hold phase
`timescale 1ns/1ns
module adcsc_top
    import adcsc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        frame_sel_n,
    input  wire logic        sclk,
    input  wire logic        sdi,
    input  wire logic [11:0] conv_result,
    output logic             sdo,
    output logic             sdo_oe,
    output logic [2:0]       mux_sel,
    output logic             powered,
    output logic             track,
    output logic [2:0]       chan_field
);
    // ===========================================================
    // reset release
    logic rst_s1;
    logic rst_s2;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end

    // ===========================================================
    // edge detection
    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;
    logic cs_fall;

    adcsc_edge u_sclk (
        .clk   (clk),
        .rst_n (rst_s2),
        .sig   (sclk),
        .rise  (sclk_rise),
        .fall  (sclk_fall)
    );

    adcsc_edge u_cs (
        .clk   (clk),
        .rst_n (rst_s2),
        .sig   (frame_sel_n),
        .rise  (cs_rise),
        .fall  (cs_fall)
    );

    // clock gated off while frame high; frame fall with sclk low counts as a falling edge
    logic  active;
    logic  g_rise;
    logic  g_fall;
    assign active = ~frame_sel_n;
    assign g_rise = active & sclk_rise;
    assign g_fall = active & (sclk_fall | (cs_fall & ~sclk));

    // channel field extraction, used by the chan_next and chan_field latch
    function automatic logic [2:0] chan_of(input logic [7:0] b);
        chan_of = b[CHAN_MSB:CHAN_LSB];
    endfunction

    // ===========================================================
    // sequencing state
    logic [4:0]   rise_cnt;
    logic [4:0]   fall_cnt;
    logic [7:0]   ctrl_shift;
    logic [2:0]   chan_next;
    logic [11:0]  result_sr;
    adcsc_phase_t phase;
    logic [4:0]   next_rise_cnt;
    logic [4:0]   next_fall_cnt;
    logic [7:0]   next_ctrl_shift;
    logic [2:0]   next_chan_next;
    logic [11:0]  next_result_sr;
    adcsc_phase_t next_phase;
    logic         next_sdo;
    logic         next_sdo_oe;
    logic [2:0]   next_mux_sel;
    logic [2:0]   next_chan_field;

    // next-state of counters, control shift, output shift
    always_comb begin
        next_rise_cnt   = rise_cnt;
        next_fall_cnt   = fall_cnt;
        next_ctrl_shift = ctrl_shift;
        next_chan_next  = chan_next;
        next_result_sr  = result_sr;
        next_phase      = phase;
        next_sdo        = sdo;
        next_mux_sel    = mux_sel;
        next_sdo_oe     = active;
        next_chan_field = chan_field;
        if (!active) begin
            next_rise_cnt   = 5'h00;
            next_fall_cnt   = 5'h00;
            next_ctrl_shift = CTRL_RESET;
            next_phase      = ADCSC_OFF;
            next_sdo        = 1'b0;
            if (cs_rise) begin
                next_mux_sel = chan_next;
            end
        end else begin
            if (phase == ADCSC_OFF) begin
                next_phase = ADCSC_TRACK;
            end
            // rising edges: control bits in; frame start counts only as a falling edge
            if (g_rise) begin
                if (rise_cnt < CNT_CTRL_END) begin
                    next_ctrl_shift = {ctrl_shift[6:0], sdi};
                end
                if (rise_cnt == CNT_CTRL_END - 5'h01) begin
                    // channel takes effect at the next conversion
                    next_chan_next  = chan_of({ctrl_shift[6:0], sdi});
                    next_chan_field = chan_of({ctrl_shift[6:0], sdi});
                end
                if (rise_cnt == CNT_LAST - 5'h01) begin
                    next_rise_cnt = 5'h00;
                    next_ctrl_shift = CTRL_RESET;
                end else begin
                    next_rise_cnt = rise_cnt + 5'h01;
                end
            end
            if (g_fall) begin
                if (fall_cnt == CNT_LAST) begin
                    next_fall_cnt = 5'h01;
                    next_phase    = ADCSC_TRACK;
                    next_mux_sel  = chan_next;
                end else begin
                    next_fall_cnt = fall_cnt + 5'h01;
                end
                if (fall_cnt == 5'h00) begin
                    next_phase = ADCSC_TRACK;
                end
                if (fall_cnt + 5'h01 == CNT_HOLD) begin
                    next_phase     = ADCSC_HOLD;
                    next_result_sr = conv_result;
                end
                if (fall_cnt + 5'h01 == CNT_LAST) begin
                    next_phase = ADCSC_SLEEP;
                end
                // leading zeros then result msb first
                if (fall_cnt + 5'h01 <= CNT_HOLD || fall_cnt == CNT_LAST) begin
                    next_sdo = 1'b0;
                end else begin
                    next_sdo       = result_sr[11];
                    next_result_sr = {result_sr[10:0], 1'b0};
                end
            end
        end
    end

    logic next_powered;
    logic next_track;
    always_comb begin
        next_powered = active & (next_phase != ADCSC_SLEEP) & (next_phase != ADCSC_OFF);
        next_track   = active & (next_phase == ADCSC_TRACK);
    end

    // registers; first conversion uses channel zero
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            rise_cnt   <= 5'h00;
            fall_cnt   <= 5'h00;
            ctrl_shift <= CTRL_RESET;
            chan_next  <= CHAN_RESET;
            mux_sel    <= CHAN_RESET;
            chan_field <= CHAN_RESET;
            result_sr  <= RESULT_RESET;
            phase      <= ADCSC_OFF;
            sdo        <= 1'b0;
            sdo_oe     <= 1'b0;
            powered    <= 1'b0;
            track      <= 1'b0;
        end else begin
            rise_cnt   <= next_rise_cnt;
            fall_cnt   <= next_fall_cnt;
            ctrl_shift <= next_ctrl_shift;
            chan_next  <= next_chan_next;
            mux_sel    <= next_mux_sel;
            chan_field <= next_chan_field;
            result_sr  <= next_result_sr;
            phase      <= next_phase;
            sdo        <= next_sdo;
            sdo_oe     <= next_sdo_oe;
            powered    <= next_powered;
            track      <= next_track;
        end
    end

    // ===========================================================
    // checks
    chk_oe_follows_frame: assert property (@(posedge clk) disable iff (!rst_s2)
        ##1 sdo_oe == $past(active))
        else $error("output enable does not follow frame select");
    chk_off_when_high: assert property (@(posedge clk) disable iff (!rst_s2)
        frame_sel_n |=> !powered)
        else $error("powered while frame select high");
    chk_counter_clears: assert property (@(posedge clk) disable iff (!rst_s2)
        frame_sel_n |=> (rise_cnt == 5'h00 && fall_cnt == 5'h00))
        else $error("counters not cleared by frame rise");
    chk_rise_bound: assert property (@(posedge clk) disable iff (!rst_s2)
        rise_cnt < CNT_LAST)
        else $error("rising edge count beyond conversion");
    chk_lead_zeros: assert property (@(posedge clk) disable iff (!rst_s2)
        (g_fall && fall_cnt < LEAD_ZEROS) |=> !sdo)
        else $error("leading zero missing");
    chk_sleep_at16: assert property (@(posedge clk) disable iff (!rst_s2)
        (g_fall && fall_cnt == 5'h0F) |=> !powered)
        else $error("no power-down at sixteenth falling edge");
    chk_hold_at4: assert property (@(posedge clk) disable iff (!rst_s2)
        (g_fall && fall_cnt == 5'h03) |=> !track)
        else $error("not holding at fourth falling edge");
    chk_chan_latch: assert property (@(posedge clk) disable iff (!rst_s2)
        (g_rise && rise_cnt == 5'h07) |=>
            (chan_next == ctrl_shift[CHAN_MSB:CHAN_LSB] && chan_field == chan_next))
        else $error("channel field not latched");
    chk_track_start: assert property (@(posedge clk) disable iff (!rst_s2)
        (cs_fall && !sclk) |=> track)
        else $error("track not entered at frame start");

    // control byte: shift on the first eight rises only, then frozen to the wrap
    chk_ctrl_shift: assert property (@(posedge clk) disable iff (!rst_s2)
        (g_rise && rise_cnt < CNT_CTRL_END) |=> ctrl_shift[0] == $past(sdi))
        else $error("input bit not shifted into control byte");
    chk_ctrl_frozen: assert property (@(posedge clk) disable iff (!rst_s2)
        (g_rise && rise_cnt >= CNT_CTRL_END && rise_cnt < 5'h0F) |=> $stable(ctrl_shift))
        else $error("control byte moved after its eighth bit");
    chk_rise_wrap: assert property (@(posedge clk) disable iff (!rst_s2)
        (g_rise && rise_cnt == 5'h0F) |=> (rise_cnt == 5'h00 && ctrl_shift == CTRL_RESET))
        else $error("conversion did not wrap at sixteenth rise");

    // channel hand-over only at a conversion boundary, never mid-conversion
    chk_mux_update: assert property (@(posedge clk) disable iff (!rst_s2)
        (g_fall && fall_cnt == CNT_LAST) |=> mux_sel == $past(chan_next))
        else $error("channel not applied at next conversion");
    chk_frame_end_mux: assert property (@(posedge clk) disable iff (!rst_s2)
        cs_rise |=> mux_sel == $past(chan_next))
        else $error("channel not applied at frame end");

    // track and hold; a late hold would smear the sampled input
    chk_track_first: assert property (@(posedge clk) disable iff (!rst_s2)
        (g_fall && fall_cnt < TRACK_CYCLES) |=> track)
        else $error("not tracking in first three cycles");
    chk_track_rearm: assert property (@(posedge clk) disable iff (!rst_s2)
        (g_fall && fall_cnt == CNT_LAST) |=> track)
        else $error("track not re-entered in continuous mode");
    chk_result_load: assert property (@(posedge clk) disable iff (!rst_s2)
        (g_fall && fall_cnt == 5'h03) |=> result_sr == $past(conv_result))
        else $error("result not captured at hold");
    chk_cont_zero: assert property (@(posedge clk) disable iff (!rst_s2)
        (g_fall && fall_cnt == CNT_LAST) |=> !sdo)
        else $error("leading zero missing in continuous mode");

    // power: up through a conversion, down from sixteenth fall to next first fall
    chk_powered_frame: assert property (@(posedge clk) disable iff (!rst_s2)
        (active && phase != ADCSC_SLEEP && !(g_fall && fall_cnt == 5'h0F)) |=> powered)
        else $error("not powered inside conversion");
    chk_sleep_holds: assert property (@(posedge clk) disable iff (!rst_s2)
        (active && phase == ADCSC_SLEEP && !g_fall) |=> !powered)
        else $error("woke before next falling edge");

    // ===========================================================
    // cover points
    cov_frame: cover property (@(posedge clk) disable iff (!rst_s2) cs_fall ##[1:400] cs_rise);
    cov_sleep: cover property (@(posedge clk) disable iff (!rst_s2) phase == ADCSC_SLEEP);
    cov_chan7: cover property (@(posedge clk) disable iff (!rst_s2) chan_next == 3'h7);
    cov_cont: cover property (@(posedge clk) disable iff (!rst_s2)
        g_fall && fall_cnt == CNT_LAST);
    cov_short_frame: cover property (@(posedge clk) disable iff (!rst_s2)
        cs_rise && rise_cnt != 5'h00);
endmodule

// [sim/adcsc_host.sv]
// host serial master model: frame select, serial clock, control bytes
// assumes clk is the device system clock; every pin moves at falling clk
`timescale 1ns/1ns
module adcsc_host (
    input  wire logic clk,
    input  wire logic sdo,
    input  wire logic powered,
    input  wire logic track,
    output logic      frame_sel_n,
    output logic      sclk,
    output logic      sdi
);
    // =====================================================
    // idle pins: frame high, clock parked low and still
    initial begin
        frame_sel_n = 1'b1;
        sclk        = 1'b0;
        sdi         = 1'b0;
    end
    // =====================================================
    // frame start; mode 0 clock low, 1 clock high first, 2 both fall at once
    task automatic open_frame(input int mode);
        if (mode != 0) begin
            sclk = 1'b1;
            repeat (3) @(negedge clk);
        end
        frame_sel_n = 1'b0;
        if (mode == 1) begin
            repeat (3) @(negedge clk);
        end
        sclk = 1'b0;
    endtask
    // =====================================================
    // one conversion of nb rising edges; 3 clk per half keeps edges visible
    task automatic convert(input logic [7:0] ctrl, input int nb, input bit last,
                           output logic [15:0] rx, output logic [15:0] trk,
                           output logic [15:0] pwr);
        for (int i = 0; i < nb; i++) begin
            sdi = (i < 8) ? ctrl[7-i] : ~sdi;
            repeat (3) @(negedge clk);
            rx[15-i]  = sdo;
            trk[15-i] = track;
            pwr[15-i] = powered;
            sclk = 1'b1;
            repeat (3) @(negedge clk);
            if (i < nb - 1 || !last) sclk = 1'b0;
        end
        if (last) begin
            frame_sel_n = 1'b1;
            repeat (2) @(negedge clk);
            sclk = 1'b0;
            sdi  = ~sdi; // released line must not keep its last value
        end
    endtask
endmodule

// [sim/tb_adc_serial_channel_control.sv]
// testbench: host model drives frames, bench models the converter core
// assumes the core answers channel n with code {4{n}}, spanning 000 to FFF
`timescale 1ns/1ns
module tb_adc_serial_channel_control
    import adcsc_pkg::*;
;
    logic        clk, rst_n, frame_sel_n, sclk, sdi, sdo, sdo_oe, powered, track;
    logic [11:0] conv_result;
    logic [2:0]  mux_sel, chan_field, prev;
    logic [15:0] rx, trk, pwr;
    int          errors, checks;
    // =====================================================
    // clock, reset and core model
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        rst_n       = 1'b0;
        conv_result = RESULT_RESET;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
    end
    always @(negedge clk) conv_result <= {4{mux_sel}};
    adcsc_top u_dut (.clk(clk), .rst_n(rst_n), .frame_sel_n(frame_sel_n), .sclk(sclk),
        .sdi(sdi), .conv_result(conv_result), .sdo(sdo), .sdo_oe(sdo_oe),
        .mux_sel(mux_sel), .powered(powered), .track(track), .chan_field(chan_field));
    adcsc_host u_host (.clk(clk), .sdo(sdo), .powered(powered), .track(track),
        .frame_sel_n(frame_sel_n), .sclk(sclk), .sdi(sdi));
    // =====================================================
    // compare, conversion and closing helpers
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // expected code is that of the channel latched one conversion earlier
    task automatic conv(input logic [2:0] ch, input bit last);
        u_host.convert({ch[1], ~ch[0], ch, ch[2], ch[0], ~ch[1]}, 16, last, rx, trk, pwr);
        chk("result", {4'h0, {4{prev}}}, rx);
        chk("track", 16'hE000, trk);
        chk("power", 16'hFFFE, pwr);
        prev = ch;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // =====================================================
    // watchdog well past the ~1150 cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
    // =====================================================
    // main sequence: three frame orderings, all channels, then an abort
    initial begin
        errors = 0;
        checks = 0;
        prev   = CHAN_RESET;
        @(posedge rst_n);
        repeat (4) @(negedge clk);
        for (int m = 0; m < 3; m++) begin
            u_host.open_frame(m);
            repeat (2) @(negedge clk);
            chk("oe in frame", 16'h1, 16'(sdo_oe));
            for (int k = 0; k < 3; k++) conv(3'(m * 3 + k + 5), k == 2);
            repeat (4) @(negedge clk);
            chk("oe idle", 16'h0, 16'(sdo_oe));
            chk("powered idle", 16'h0, 16'(powered));
            chk("chan field", 16'(prev), 16'(chan_field));
            chk("mux", 16'(prev), 16'(mux_sel));
            repeat (20) @(negedge clk);
            $display("test frame order %0d done", m);
        end
        // short frame: next frame must restart at conversion cycle one
        u_host.open_frame(0);
        u_host.convert(8'h18, 10, 1'b1, rx, trk, pwr);
        prev = 3'h3;
        repeat (10) @(negedge clk);
        u_host.open_frame(0);
        conv(3'h0, 1'b1);
        $display("test aborted frame done");
        tally_and_finish();
    end
endmodule
